//--- rtl/ipsb_cfg.svh
// Offsets, field layouts and reset values of the upper set-pending bank
`ifndef IPSB_CFG_SVH
`define IPSB_CFG_SVH

`define IPSB_ADDR_W        12
`define IPSB_OFF_FORCE     12'h000
`define IPSB_OFF_CLEAR     12'h004
`define IPSB_OFF_ENABLE    12'h008
`define IPSB_OFF_STATUS    12'h00C
`define IPSB_OFF_MASK      12'h010

`define IPSB_LINE_BASE     64
`define IPSB_IMPL_MASK     32'hFFFF3FFF
`define IPSB_HOLE_LSB      14
`define IPSB_HOLE_MSB      15

`define IPSB_RST_PEND      32'h00000000
`define IPSB_RST_ENABLE    32'h00000000
`define IPSB_RST_STATUS    32'h00000000
`define IPSB_RST_MASK      32'h00000000
`define IPSB_RST_RDATA     32'h00000000

`endif

//--- rtl/ipsb_pkg.sv
// Types shared by the upper set-pending bank
package ipsb_pkg;

   typedef logic [31:0] ipsb_word_t;

   typedef enum logic [2:0]
   {
      IPSB_SEL_FORCE  = 3'h0,
      IPSB_SEL_CLEAR  = 3'h1,
      IPSB_SEL_ENABLE = 3'h3,
      IPSB_SEL_STATUS = 3'h2,
      IPSB_SEL_MASK   = 3'h6,
      IPSB_SEL_NONE   = 3'h7
   } ipsb_sel_t;

endpackage : ipsb_pkg

//--- rtl/ipsb_line.sv
// One interrupt line: source synchroniser, pending flag and pend-event flag
`timescale 1ns/1ps
module ipsb_line
(
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic src_i,
   input  wire logic enable_i,
   input  wire logic force_i,
   input  wire logic clear_i,
   input  wire logic evt_clr_i,
   output logic      pend_o,
   output logic      evt_o
);

   logic sync1_reg;
   logic sync2_reg;
   logic pend_reg;
   logic pend_next;
   logic evt_reg;
   logic evt_next;
   logic set_req;

   // Source comes from another domain; only the second stage is read
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= src_i;
         sync2_reg <= sync1_reg;
      end
   end

   // Disabled line takes no forced pend; already pending stays as is
   assign set_req = enable_i & (force_i | sync2_reg);

   always_comb
   begin
      pend_next = pend_reg;
      if (clear_i)
      begin
         pend_next = 1'b0;
      end
      // Set wins so an event landing on a clear is not lost
      if (set_req)
      begin
         pend_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pend_reg <= 1'b0;
      end
      else
      begin
         pend_reg <= pend_next;
      end
   end

   always_comb
   begin
      evt_next = evt_reg;
      if (evt_clr_i)
      begin
         evt_next = 1'b0;
      end
      if (pend_next & ~pend_reg)
      begin
         evt_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         evt_reg <= 1'b0;
      end
      else
      begin
         evt_reg <= evt_next;
      end
   end

   assign pend_o = pend_reg;
   assign evt_o  = evt_reg;

endmodule : ipsb_line

//--- rtl/ipsb_top.sv
// APB slave holding the force-pending, clear-pending, enable and event registers of lines 64..95
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ipsb_cfg.svh"
module ipsb_top
#(
   parameter int unsigned  ADDR_W    = `IPSB_ADDR_W,
   parameter logic [31:0]  IMPL_MASK = `IPSB_IMPL_MASK
)
(
   input  wire logic              CLK_I,
   input  wire logic              NRST_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic [31:0]            PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic [31:0]       IRQ_SRC_I,
   output logic [31:0]            PEND_O,
   output logic                   IRQ_O
);

   ipsb_pkg::ipsb_sel_t sel;
   logic                setup_phase;
   logic                wr_access;
   logic                wr_force;
   logic                wr_clear;
   logic                wr_enable;
   logic                wr_status;
   logic                wr_mask;
   logic [31:0]         wdata_impl;
   logic [31:0]         force_wr;
   logic [31:0]         clear_wr;
   logic [31:0]         evt_clr_wr;
   logic [31:0]         pend_vec;
   logic [31:0]         evt_vec;
   logic [31:0]         enable_reg;
   logic [31:0]         enable_next;
   logic [31:0]         mask_reg;
   logic [31:0]         mask_next;
   logic [31:0]         rdata_reg;
   logic [31:0]         rdata_next;
   logic                unmapped_reg;
   logic                irq_reg;

   // Address decode, full word match; anything else is unmapped
   always_comb
   begin
      unique case (PADDR_I)
         `IPSB_OFF_FORCE:  sel = ipsb_pkg::IPSB_SEL_FORCE;
         `IPSB_OFF_CLEAR:  sel = ipsb_pkg::IPSB_SEL_CLEAR;
         `IPSB_OFF_ENABLE: sel = ipsb_pkg::IPSB_SEL_ENABLE;
         `IPSB_OFF_STATUS: sel = ipsb_pkg::IPSB_SEL_STATUS;
         `IPSB_OFF_MASK:   sel = ipsb_pkg::IPSB_SEL_MASK;
         default:          sel = ipsb_pkg::IPSB_SEL_NONE;
      endcase
   end

   assign setup_phase = PSEL_I & ~PENABLE_I;
   assign wr_access   = PSEL_I & PENABLE_I & PWRITE_I;

   // One strobe per register, high only in the access cycle of a write to it
   always_comb
   begin
      wr_force  = 1'b0;
      wr_clear  = 1'b0;
      wr_enable = 1'b0;
      wr_status = 1'b0;
      wr_mask   = 1'b0;
      if (wr_access)
      begin
         unique case (sel)
            ipsb_pkg::IPSB_SEL_FORCE:  wr_force  = 1'b1;
            ipsb_pkg::IPSB_SEL_CLEAR:  wr_clear  = 1'b1;
            ipsb_pkg::IPSB_SEL_ENABLE: wr_enable = 1'b1;
            ipsb_pkg::IPSB_SEL_STATUS: wr_status = 1'b1;
            ipsb_pkg::IPSB_SEL_MASK:   wr_mask   = 1'b1;
            ipsb_pkg::IPSB_SEL_NONE:   wr_force  = 1'b0; // Unmapped writes are dropped
         endcase
      end
   end

   // Holes at 15..14 carry no line, so their data is dropped here
   assign wdata_impl = PWDATA_I & IMPL_MASK;

   // Only ones act; zeros in the write data leave every line alone
   assign force_wr   = wr_force  ? wdata_impl : 32'h00000000;
   assign clear_wr   = wr_clear  ? wdata_impl : 32'h00000000;
   assign evt_clr_wr = wr_status ? wdata_impl : 32'h00000000;

   // Bit n of each word serves line 64+n
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++)
      begin : g_line
         if (IMPL_MASK[gi])
         begin : g_impl
            ipsb_line u_line
            (
               .clk_i     (CLK_I),
               .nrst_i    (NRST_I),
               .src_i     (IRQ_SRC_I[gi]),
               .enable_i  (enable_reg[gi]),
               .force_i   (force_wr[gi]),
               .clear_i   (clear_wr[gi]),
               .evt_clr_i (evt_clr_wr[gi]),
               .pend_o    (pend_vec[gi]),
               .evt_o     (evt_vec[gi])
            );
         end
         else
         begin : g_hole
            assign pend_vec[gi] = 1'b0;
            assign evt_vec[gi]  = 1'b0;
         end
      end
   endgenerate

   always_comb
   begin
      enable_next = enable_reg;
      if (wr_enable)
      begin
         enable_next = wdata_impl;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         enable_reg <= `IPSB_RST_ENABLE;
      end
      else
      begin
         enable_reg <= enable_next;
      end
   end

   always_comb
   begin
      mask_next = mask_reg;
      if (wr_mask)
      begin
         mask_next = wdata_impl;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         mask_reg <= `IPSB_RST_MASK;
      end
      else
      begin
         mask_reg <= mask_next;
      end
   end

   // Read data is captured in setup, so it is a snapshot of the selected register one edge old
   always_comb
   begin
      rdata_next = rdata_reg;
      if (setup_phase)
      begin
         unique case (sel)
            ipsb_pkg::IPSB_SEL_FORCE:  rdata_next = pend_vec;
            ipsb_pkg::IPSB_SEL_CLEAR:  rdata_next = pend_vec;
            ipsb_pkg::IPSB_SEL_ENABLE: rdata_next = enable_reg;
            ipsb_pkg::IPSB_SEL_STATUS: rdata_next = evt_vec;
            ipsb_pkg::IPSB_SEL_MASK:   rdata_next = mask_reg;
            ipsb_pkg::IPSB_SEL_NONE:   rdata_next = `IPSB_RST_RDATA;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         rdata_reg <= `IPSB_RST_RDATA;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         unmapped_reg <= 1'b0;
      end
      else if (setup_phase)
      begin
         unmapped_reg <= (sel == ipsb_pkg::IPSB_SEL_NONE);
      end
   end

   // Registered to keep the interrupt output glitch free
   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(evt_vec & mask_reg);
      end
   end

   // Zero wait states: every access completes in its first access cycle
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & unmapped_reg;
   assign PRDATA_O  = rdata_reg;
   assign PEND_O    = pend_vec;
   assign IRQ_O     = irq_reg;

endmodule : ipsb_top

//--- verification/ipsb_chk.sv
// Port assertions for the upper set-pending bank
`timescale 1ns/1ps
module ipsb_chk
#(
   parameter int unsigned ADDR_W    = 12,
   parameter logic [31:0] IMPL_MASK = 32'hFFFF3FFF
)
(
   input wire logic              CLK_I,
   input wire logic              NRST_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0]       PWDATA_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic [31:0]       IRQ_SRC_I,
   input wire logic [31:0]       PEND_O,
   input wire logic              IRQ_O
);
   logic        acc;
   logic        mapped;
   logic [31:0] fset;
   logic [31:0] fclr;
   assign acc    = PSEL_I & PENABLE_I;
   assign mapped = (PADDR_I <= 12'h010) && (PADDR_I[1:0] == 2'h0);
   assign fset   = (acc & PWRITE_I & (PADDR_I == 12'h000)) ? PWDATA_I : 32'h00000000;
   assign fclr   = (acc & PWRITE_I & (PADDR_I == 12'h004)) ? PWDATA_I : 32'h00000000;
   // Sources reach the flags through a synchroniser, so a window of past edges excuses them
   default clocking dc @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   hole_zero_a: assert property (PEND_O[15:14] == 2'h0)
      else $error("hole bit pending");
   set_cause_a: assert property ((PEND_O & ~$past(PEND_O) & ~($past(fset) | $past(IRQ_SRC_I, 2)
      | $past(IRQ_SRC_I, 3) | $past(IRQ_SRC_I, 4))) == 32'h00000000)
      else $error("pending rose without cause");
   drop_cause_a: assert property ((~PEND_O & $past(PEND_O) & ~$past(fclr)) == 32'h00000000)
      else $error("pending fell without clear");
   clear_takes_a: assert property ((|fclr) |=> ((PEND_O & $past(fclr) & ~($past(IRQ_SRC_I, 1)
      | $past(IRQ_SRC_I, 2) | $past(IRQ_SRC_I, 3))) == 32'h00000000))
      else $error("clear did not clear");
   read_live_a: assert property ((acc & !PWRITE_I & (PADDR_I == 12'h000)) |-> (PRDATA_O == $past(PEND_O)))
      else $error("read data not pending state");
   slave_err_a: assert property (acc |-> (PSLVERR_O == !mapped))
      else $error("error response wrong");
   ready_now_a: assert property (acc |-> PREADY_O)
      else $error("ready low in access phase");
endmodule : ipsb_chk

bind ipsb_top ipsb_chk #(.ADDR_W(ADDR_W), .IMPL_MASK(IMPL_MASK)) chk_u (.CLK_I, .NRST_I, .PSEL_I,
   .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_SRC_I, .PEND_O, .IRQ_O);

//--- verification/irq_pending_set_bank_upper_bench.sv
// Self-checking bench for the upper set-pending bank
`timescale 1ns/1ps
module irq_pending_set_bank_upper_bench;
   logic        CLK_I, NRST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, IRQ_O, se;
   logic [11:0] PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, IRQ_SRC_I, PEND_O, q, en, pm, d;
   int          seed = 76;
   int          err_total = 0;
   int          compares = 0;
   localparam logic [31:0] IMPL = 32'hFFFF3FFF;
   // Pending word after one write: forces land on enabled lines only, clears drop bits
   function automatic logic [31:0] model_pend(input logic [31:0] p, input logic [31:0] e, input logic [31:0] f,
      input logic [31:0] c);
      return ((p | (f & e)) & ~c) & IMPL;
   endfunction : model_pend
   ipsb_top dut_u (.CLK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
      .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_SRC_I, .PEND_O, .IRQ_O);
   task summarize;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Request held until the edge where ready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge CLK_I);
      PSEL_I    <= 1'b1;
      PENABLE_I <= 1'b0;
      PWRITE_I  <= w;
      PADDR_I   <= a;
      PWDATA_I  <= wd;
      @(posedge CLK_I);
      PENABLE_I <= 1'b1;
      do @(posedge CLK_I); while (PREADY_O !== 1'b1);
      q  = PRDATA_O;
      se = PSLVERR_O;
      PSEL_I    <= 1'b0;
      PENABLE_I <= 1'b0;
   endtask : apb
   initial
   begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end
   initial
   begin
      #300000;
      err_total++;
      summarize();
   end
   initial
   begin
      {NRST_I, PSEL_I, PENABLE_I, PWRITE_I} = 4'h0;
      PADDR_I = 12'h000;
      PWDATA_I = 32'h00000000;
      IRQ_SRC_I = 32'h00000000;
      repeat (8) @(posedge CLK_I);
      NRST_I <= 1'b1;
      apb(1'b0, 12'h000, 32'h00000000);
      chk("pend after reset", 32'h00000000, q);
      $display("reset test done");
      repeat (6)
      begin
         en = $random(seed);
         d = $random(seed);
         apb(1'b1, 12'h004, 32'hFFFFFFFF);
         apb(1'b1, 12'h008, en);
         apb(1'b1, 12'h000, d & IMPL);
         pm = model_pend(32'h00000000, en, d, 32'h00000000);
         apb(1'b0, 12'h000, 32'h00000000);
         chk("force read", pm, q);
         apb(1'b1, 12'h000, (pm | ~en) & IMPL);
         pm = model_pend(pm, en, (pm | ~en) & IMPL, 32'h00000000);
         apb(1'b1, 12'h000, 32'h00000000);
         chk("pend out", pm, PEND_O);
         d = $random(seed);
         apb(1'b1, 12'h004, d);
         pm = model_pend(pm, en, 32'h00000000, d);
         apb(1'b0, 12'h004, 32'h00000000);
         chk("clear read", pm, q);
      end
      $display("force and clear test done");
      apb(1'b0, 12'h020, 32'h00000000);
      chk("unmapped err", 32'h00000001, {31'h0, se});
      chk("unmapped data", 32'h00000000, q);
      $display("unmapped test done");
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b1, 12'h00C, 32'hFFFFFFFF);
      apb(1'b1, 12'h008, 32'hFFFFFFFF);
      apb(1'b1, 12'h010, 32'h00000020);
      apb(1'b0, 12'h008, 32'h00000000);
      chk("enable read", IMPL, q);
      apb(1'b0, 12'h010, 32'h00000000);
      chk("mask read", 32'h00000020, q);
      apb(1'b1, 12'h000, 32'h00000021);
      repeat (3) @(posedge CLK_I);
      chk("irq raised", 32'h00000001, {31'h0, IRQ_O});
      apb(1'b0, 12'h00C, 32'h00000000);
      chk("status", 32'h00000021, q);
      apb(1'b1, 12'h010, 32'h00000000);
      repeat (3) @(posedge CLK_I);
      chk("irq masked", 32'h00000000, {31'h0, IRQ_O});
      apb(1'b1, 12'h010, 32'h00000020);
      apb(1'b1, 12'h00C, 32'h00000020);
      repeat (3) @(posedge CLK_I);
      chk("irq cleared", 32'h00000000, {31'h0, IRQ_O});
      $display("interrupt test done");
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      d = $random(seed);
      IRQ_SRC_I <= d;
      repeat (6) @(posedge CLK_I);
      chk("source pend", model_pend(32'h00000000, 32'hFFFFFFFF, d, 32'h00000000), PEND_O);
      IRQ_SRC_I <= 32'h00000000;
      repeat (5) @(posedge CLK_I);
      apb(1'b1, 12'h004, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h00000000);
      chk("source cleared", 32'h00000000, q);
      $display("source test done");
      summarize();
   end
endmodule : irq_pending_set_bank_upper_bench
